// ==== verilog/cita_core.sv ====
`timescale 1ns/1ps
`include "cita_defs.svh"
module cita_core (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  output logic [15:0] pc_out,
  output logic [7:0] acc_out,
  output logic [15:0] index_out,
  output logic [15:0] stack_out,
  output logic [7:0] flags_out
);
  ////////////////////////////////////////////////////////////////////////
  cita_pkg::cita_state_e st_q, st_d, ret_q, ret_d;
  logic [15:0] pc_q, pc_d, hx_q, hx_d, sp_q, sp_d, addr_q, addr_d;
  logic [7:0] a_q, a_d, flags_q, flags_d, op_q, op_d, b0_q, b0_d, b1_q, b1_d;
  logic [7:0] wdata_q, wdata_d;
  logic [3:0] step_q, step_d;
  logic [1:0] cnt_q, cnt_d;
  logic pre_q, pre_d, rd_q, rd_d, wr_q, wr_d;
  cita_pkg::cita_mode_e mode_w;
  logic [7:0] rr_w;
  cita_agu_if agu_if ();
  assign mem_addr_out = addr_q;
  assign mem_rd_out = rd_q;
  assign mem_wr_out = wr_q;
  assign mem_wdata_out = wdata_q;
  assign pc_out = pc_q;
  assign acc_out = a_q;
  assign index_out = hx_q;
  assign stack_out = sp_q;
  assign flags_out = flags_q;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] opnd_count(input logic pre, input logic [7:0] op);
    logic [1:0] n;
    n = 2'h0;
    if (pre) begin
      if (op == `CITA_OP_FTEST_SPB) n = 2'h1;
      if (op == `CITA_OP_CBEQ_SPB) n = 2'h2;
    end else if (op[7:4] == 4'h0) begin
      n = 2'h2;
    end else begin
      case (op)
        `CITA_OP_FTEST_DIR, `CITA_OP_FTEST_IXB, `CITA_OP_CBEQ_IX,
        `CITA_OP_MOV_DIXP, `CITA_OP_MOV_IXPD: n = 2'h1;
        `CITA_OP_LDA_LONG, `CITA_OP_LDA_IXW, `CITA_OP_CBEQ_DIR,
        `CITA_OP_CBEQ_IXBP, `CITA_OP_MOV_D2D, `CITA_OP_MOV_I2D: n = 2'h2;
        default: n = 2'h0;
      endcase
    end
    return n;
  endfunction : opnd_count
  function automatic cita_pkg::cita_mode_e mem_mode(input logic pre, input logic [7:0] op);
    cita_pkg::cita_mode_e m;
    m = cita_pkg::AM_NONE;
    if (pre) begin
      if (op == `CITA_OP_FTEST_SPB || op == `CITA_OP_CBEQ_SPB) m = cita_pkg::AM_SPB;
    end else if (op[7:4] == 4'h0) begin
      m = cita_pkg::AM_DIR;
    end else begin
      case (op)
        `CITA_OP_FTEST_DIR, `CITA_OP_CBEQ_DIR, `CITA_OP_MOV_D2D,
        `CITA_OP_MOV_DIXP: m = cita_pkg::AM_DIR;
        `CITA_OP_FTEST_IXB, `CITA_OP_CBEQ_IXBP: m = cita_pkg::AM_IX1;
        `CITA_OP_FTEST_IX, `CITA_OP_CBEQ_IX, `CITA_OP_MOV_IXPD: m = cita_pkg::AM_IX;
        `CITA_OP_LDA_LONG: m = cita_pkg::AM_LONG;
        `CITA_OP_LDA_IXW: m = cita_pkg::AM_IXW;
        default: m = cita_pkg::AM_NONE;
      endcase
    end
    return m;
  endfunction : mem_mode
  function automatic logic [7:0] ftest_flags(input logic [7:0] f, input logic [7:0] v);
    logic [7:0] c;
    c = f;
    c[`CITA_FLAGS_V] = 1'b0;
    c[`CITA_FLAGS_N] = v[7];
    c[`CITA_FLAGS_Z] = (v == 8'h00);
    return c;
  endfunction : ftest_flags
  ////////////////////////////////////////////////////////////////////////
  assign mode_w = mem_mode(pre_q, op_q);
  assign agu_if.mode = mode_w;
  assign agu_if.hx = hx_q;
  assign agu_if.sp = sp_q;
  assign agu_if.b0 = b0_q;
  assign agu_if.b1 = b1_q;
  // Only the no-offset post-increment compare has its offset in the first byte
  assign rr_w = (!pre_q && op_q == `CITA_OP_CBEQ_IX) ? b0_q : b1_q;

  cita_agu u_agu (
    .bus(agu_if.agu)
  );
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    ret_d = ret_q;
    {pc_d, hx_d, sp_d, addr_d} = {pc_q, hx_q, sp_q, addr_q};
    {a_d, flags_d, op_d, b0_d, b1_d, wdata_d} = {a_q, flags_q, op_q, b0_q, b1_q, wdata_q};
    {pre_d, cnt_d, step_d} = {pre_q, cnt_q, step_q};
    rd_d = 1'b0;
    wr_d = 1'b0;
    unique case (st_q)
      cita_pkg::ST_FETCH: begin
        addr_d = pc_q;
        rd_d = 1'b1;
        pc_d = pc_q + 16'h0001;
        pre_d = 1'b0;
        ret_d = cita_pkg::ST_DECODE;
        st_d = cita_pkg::ST_WAIT;
      end
      cita_pkg::ST_WAIT: st_d = ret_q;
      cita_pkg::ST_DECODE: begin
        cnt_d = 2'h0;
        if (!pre_q && mem_rdata_in == `CITA_OP_PREFIX) begin
          pre_d = 1'b1;
          addr_d = pc_q;
          rd_d = 1'b1;
          pc_d = pc_q + 16'h0001;
          st_d = cita_pkg::ST_WAIT;
        end else if (opnd_count(pre_q, mem_rdata_in) != 2'h0) begin
          op_d = mem_rdata_in;
          addr_d = pc_q;
          rd_d = 1'b1;
          pc_d = pc_q + 16'h0001;
          ret_d = cita_pkg::ST_OPND;
          st_d = cita_pkg::ST_WAIT;
        end else begin
          op_d = mem_rdata_in;
          st_d = cita_pkg::ST_EXEC;
        end
      end
      cita_pkg::ST_OPND: begin
        // First stream byte lands in b0: high byte of an extended address or wide offset, else the whole first operand
        if (cnt_q == 2'h0) b0_d = mem_rdata_in;
        else b1_d = mem_rdata_in;
        cnt_d = cnt_q + 2'h1;
        if (cnt_q + 2'h1 < opnd_count(pre_q, op_q)) begin
          addr_d = pc_q;
          rd_d = 1'b1;
          pc_d = pc_q + 16'h0001;
          st_d = cita_pkg::ST_WAIT;
        end else begin
          st_d = cita_pkg::ST_EXEC;
        end
      end
      cita_pkg::ST_EXEC: begin
        st_d = cita_pkg::ST_FETCH;
        step_d = 4'h0;
        if (pre_q) begin
          if (mode_w != cita_pkg::AM_NONE) begin
            addr_d = agu_if.ea;
            rd_d = 1'b1;
            ret_d = cita_pkg::ST_MEMD;
            st_d = cita_pkg::ST_WAIT;
          end
        end else if (op_q == `CITA_OP_TRAP) st_d = cita_pkg::ST_TRAP;
        else if (op_q == `CITA_OP_ACC_TO_FLAGS) flags_d = a_q | `CITA_FLAGS_ONES;
        else if (op_q == `CITA_OP_FLAGS_TO_ACC) a_d = flags_q;
        else if (op_q == `CITA_OP_ACC_TO_XL) hx_d[7:0] = a_q;
        else if (op_q == `CITA_OP_XL_TO_ACC) a_d = hx_q[7:0];
        else if (op_q == `CITA_OP_SP_TO_HX) hx_d = sp_q + 16'h0001;
        else if (op_q == `CITA_OP_HX_TO_SP) sp_d = hx_q - 16'h0001;
        else if (op_q == `CITA_OP_FTEST_A) flags_d = ftest_flags(flags_q, a_q);
        else if (op_q == `CITA_OP_FTEST_X) flags_d = ftest_flags(flags_q, hx_q[7:0]);
        else if (op_q == `CITA_OP_MOV_I2D) begin
          addr_d = {8'h00, b1_q};
          wdata_d = b0_q;
          wr_d = 1'b1;
        end else if (mode_w != cita_pkg::AM_NONE) begin
          addr_d = agu_if.ea;
          rd_d = 1'b1;
          ret_d = cita_pkg::ST_MEMD;
          st_d = cita_pkg::ST_WAIT;
        end
      end
      cita_pkg::ST_MEMD: begin
        st_d = cita_pkg::ST_FETCH;
        if (!pre_q && op_q[7:4] == 4'h0) begin
          // Bit number in op[3:1], op[0] low branches on a set bit
          flags_d[`CITA_FLAGS_C] = mem_rdata_in[op_q[3:1]];
          if (mem_rdata_in[op_q[3:1]] != op_q[0]) pc_d = pc_q + {{8{b1_q[7]}}, b1_q};
        end else if (op_q[3:0] == 4'hd) begin
          flags_d = ftest_flags(flags_q, mem_rdata_in);
        end else if (op_q[3:0] == 4'h1) begin
          if (mem_rdata_in == a_q) pc_d = pc_q + {{8{rr_w[7]}}, rr_w};
          if (mode_w != cita_pkg::AM_DIR && mode_w != cita_pkg::AM_SPB) begin
            hx_d = hx_q + 16'h0001;
          end
        end else if (op_q == `CITA_OP_LDA_LONG || op_q == `CITA_OP_LDA_IXW) begin
          a_d = mem_rdata_in;
          flags_d = ftest_flags(flags_q, mem_rdata_in);
        end else begin
          wr_d = 1'b1;
          wdata_d = mem_rdata_in;
          if (op_q == `CITA_OP_MOV_D2D) addr_d = {8'h00, b1_q};
          else if (op_q == `CITA_OP_MOV_DIXP) addr_d = hx_q;
          else addr_d = {8'h00, b0_q};
          if (op_q != `CITA_OP_MOV_D2D) hx_d = hx_q + 16'h0001;
        end
      end
      cita_pkg::ST_TRAP: begin
        step_d = step_q + 4'h1;
        if (step_q < `CITA_TRAP_VEC) begin
          // Stack grows down; each push lands before the pointer moves
          addr_d = sp_q;
          wr_d = 1'b1;
          sp_d = sp_q - 16'h0001;
          case (step_q)
            4'h0: wdata_d = pc_q[7:0];
            4'h1: wdata_d = pc_q[15:8];
            4'h2: wdata_d = hx_q[7:0];
            4'h3: wdata_d = a_q;
            default: wdata_d = flags_q;
          endcase
        end else if (step_q == `CITA_TRAP_VEC) begin
          flags_d[`CITA_FLAGS_I] = 1'b1;
          addr_d = `CITA_VEC_HI;
          rd_d = 1'b1;
        end else if (step_q == `CITA_TRAP_VEC + 4'h1) begin
          addr_d = `CITA_VEC_LO;
          rd_d = 1'b1;
        end else if (step_q == `CITA_TRAP_VEC + 4'h2) begin
          pc_d[15:8] = mem_rdata_in;
        end else begin
          pc_d[7:0] = mem_rdata_in;
          st_d = cita_pkg::ST_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= cita_pkg::ST_FETCH;
      ret_q <= cita_pkg::ST_DECODE;
      {pc_q, hx_q, sp_q, addr_q} <= {`CITA_PC_RST, 16'h0000, `CITA_SP_RST, 16'h0000};
      {a_q, flags_q, op_q} <= {8'h00, `CITA_FLAGS_RST, 8'h00};
      {b0_q, b1_q, wdata_q} <= {8'h00, 8'h00, 8'h00};
      {pre_q, cnt_q, step_q, rd_q, wr_q} <= {1'b0, 2'h0, 4'h0, 1'b0, 1'b0};
    end else begin
      st_q <= st_d;
      ret_q <= ret_d;
      {pc_q, hx_q, sp_q, addr_q} <= {pc_d, hx_d, sp_d, addr_d};
      {a_q, flags_q, op_q} <= {a_d, flags_d, op_d};
      {b0_q, b1_q, wdata_q} <= {b0_d, b1_d, wdata_d};
      {pre_q, cnt_q, step_q, rd_q, wr_q} <= {pre_d, cnt_d, step_d, rd_d, wr_d};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  ftest_flags_a:
    assert property ((st_q == cita_pkg::ST_MEMD && op_q[3:0] == 4'hd && op_q[7:4] != 4'h0)
      |=> !flags_q[`CITA_FLAGS_V] && $stable(flags_q[`CITA_FLAGS_C])
      && $stable(flags_q[`CITA_FLAGS_I])
      && flags_q[`CITA_FLAGS_Z] == ($past(mem_rdata_in) == 8'h00))
    else $error("flag test result wrong");
  trap_push_a:
    assert property ((st_q == cita_pkg::ST_TRAP && step_q == 4'h0)
      |=> mem_wr_out && mem_wdata_out == pc_q[7:0] && mem_addr_out == $past(sp_q)
      ##1 mem_wr_out && mem_wdata_out == pc_q[15:8] ##1 mem_wdata_out == hx_q[7:0]
      ##1 mem_wdata_out == a_q)
    else $error("trap stacking order wrong");
  trap_mask_a:
    assert property ((st_q == cita_pkg::ST_TRAP && step_q == `CITA_TRAP_VEC)
      |=> flags_q[`CITA_FLAGS_I] && mem_rd_out && mem_addr_out == `CITA_VEC_HI
      ##1 mem_rd_out && mem_addr_out == `CITA_VEC_LO)
    else $error("trap vector fetch wrong");
  trap_len_a:
    assert property ($rose(st_q == cita_pkg::ST_TRAP)
      |-> (st_q == cita_pkg::ST_TRAP)[*8] ##1 st_q == cita_pkg::ST_TRAP
      ##1 st_q == cita_pkg::ST_FETCH && sp_q == $past(sp_q, 10) - 16'h0005)
    else $error("trap length wrong");
  long_addr_a:
    assert property ((st_q == cita_pkg::ST_EXEC && mode_w == cita_pkg::AM_LONG)
      |=> mem_rd_out && mem_addr_out == {$past(b0_q), $past(b1_q)})
    else $error("extended address wrong");
  wide_addr_a:
    assert property ((st_q == cita_pkg::ST_EXEC && mode_w == cita_pkg::AM_IXW)
      |=> mem_addr_out == $past(hx_q) + {$past(b0_q), $past(b1_q)})
    else $error("wide indexed address wrong");
  postinc_a:
    assert property ((st_q == cita_pkg::ST_MEMD && mode_w == cita_pkg::AM_IX
      && op_q != `CITA_OP_FTEST_IX) |=> hx_q == $past(hx_q) + 16'h0001)
    else $error("index pair not incremented");
  stack_addr_a:
    assert property ((st_q == cita_pkg::ST_EXEC && mode_w == cita_pkg::AM_SPB)
      |=> mem_addr_out == $past(sp_q) + {8'h00, $past(b0_q)})
    else $error("stack offset address wrong");
  imd_move_a:
    assert property ((st_q == cita_pkg::ST_EXEC && !pre_q && op_q == `CITA_OP_MOV_I2D)
      |=> mem_wr_out && mem_addr_out == {8'h00, $past(b1_q)} && mem_wdata_out == $past(b0_q))
    else $error("immediate move wrong");
  sp_to_hx_a:
    assert property ((st_q == cita_pkg::ST_EXEC && !pre_q && op_q == `CITA_OP_SP_TO_HX)
      |=> hx_q == $past(sp_q) + 16'h0001 && $stable(flags_q))
    else $error("stack to index transfer wrong");
  tap_a:
    assert property ((st_q == cita_pkg::ST_EXEC && !pre_q && op_q == `CITA_OP_ACC_TO_FLAGS)
      |=> flags_q == ($past(a_q) | `CITA_FLAGS_ONES))
    else $error("accumulator to flags wrong");
endmodule : cita_core

// ==== verilog/cita_defs.svh ====
`ifndef CITA_DEFS_SVH
`define CITA_DEFS_SVH
`define CITA_PC_RST 16'h0000
`define CITA_SP_RST 16'h00ff
`define CITA_FLAGS_RST 8'h68
`define CITA_FLAGS_ONES 8'h60
`define CITA_FLAGS_V 7
`define CITA_FLAGS_I 3
`define CITA_FLAGS_N 2
`define CITA_FLAGS_Z 1
`define CITA_FLAGS_C 0
`define CITA_VEC_HI 16'hfff0
`define CITA_VEC_LO 16'hfff1
`define CITA_TRAP_VEC 4'h5
`define CITA_TRAP_LAST 4'h8
`define CITA_OP_PREFIX 8'h9e
`define CITA_OP_TRAP 8'h83
`define CITA_OP_ACC_TO_FLAGS 8'h84
`define CITA_OP_FLAGS_TO_ACC 8'h85
`define CITA_OP_ACC_TO_XL 8'h97
`define CITA_OP_XL_TO_ACC 8'h9f
`define CITA_OP_SP_TO_HX 8'h95
`define CITA_OP_HX_TO_SP 8'h94
`define CITA_OP_FTEST_DIR 8'h3d
`define CITA_OP_FTEST_A 8'h4d
`define CITA_OP_FTEST_X 8'h5d
`define CITA_OP_FTEST_IXB 8'h6d
`define CITA_OP_FTEST_IX 8'h7d
`define CITA_OP_FTEST_SPB 8'h6d
`define CITA_OP_CBEQ_DIR 8'h31
`define CITA_OP_CBEQ_IXBP 8'h61
`define CITA_OP_CBEQ_IX 8'h71
`define CITA_OP_CBEQ_SPB 8'h61
`define CITA_OP_MOV_D2D 8'h4e
`define CITA_OP_MOV_DIXP 8'h5e
`define CITA_OP_MOV_I2D 8'h6e
`define CITA_OP_MOV_IXPD 8'h7e
`define CITA_OP_LDA_LONG 8'hc6
`define CITA_OP_LDA_IXW 8'hd6
`endif

// ==== verilog/cita_pkg.sv ====
package cita_pkg;
  typedef enum logic [6:0] {
    ST_FETCH = 7'h01,
    ST_WAIT = 7'h02,
    ST_DECODE = 7'h04,
    ST_OPND = 7'h08,
    ST_EXEC = 7'h10,
    ST_MEMD = 7'h20,
    ST_TRAP = 7'h40
  } cita_state_e;
  typedef enum logic [2:0] {
    AM_DIR = 3'h0,
    AM_LONG = 3'h1,
    AM_IXW = 3'h2,
    AM_IX1 = 3'h3,
    AM_IX = 3'h4,
    AM_SPB = 3'h5,
    AM_NONE = 3'h7
  } cita_mode_e;
endpackage : cita_pkg

// ==== verilog/cita_agu_if.sv ====
`timescale 1ns/1ps
interface cita_agu_if;
  cita_pkg::cita_mode_e mode;
  logic [15:0] hx;
  logic [15:0] sp;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [15:0] ea;
  modport core (output mode, output hx, output sp, output b0, output b1, input ea);
  modport agu (input mode, input hx, input sp, input b0, input b1, output ea);
endinterface : cita_agu_if

// ==== verilog/cita_agu.sv ====
`timescale 1ns/1ps
module cita_agu (
  cita_agu_if.agu bus
);
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    unique case (bus.mode)
      cita_pkg::AM_DIR: bus.ea = {8'h00, bus.b0};
      cita_pkg::AM_LONG: bus.ea = {bus.b0, bus.b1};
      cita_pkg::AM_IXW: bus.ea = bus.hx + {bus.b0, bus.b1};
      cita_pkg::AM_IX1: bus.ea = bus.hx + {8'h00, bus.b0};
      cita_pkg::AM_IX: bus.ea = bus.hx;
      cita_pkg::AM_SPB: bus.ea = bus.sp + {8'h00, bus.b0};
      default: bus.ea = bus.hx;
    endcase
  end
endmodule : cita_agu

// ==== tb/cita_mem_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Byte-wide program and data memory, no wait states
module cita_mem_model (
  input wire logic clock_in,
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:65535];
  logic pend_q;
  logic [15:0] pend_addr_q;
  int n_writes;
  initial begin
    rdata_out = 8'h00;
    pend_q = 1'b0;
    pend_addr_q = 16'h0000;
    n_writes = 0;
  end
  always @(posedge clock_in) begin
    pend_q <= rd_in;
    pend_addr_q <= addr_in;
    if (wr_in) begin
      mem[addr_in] <= wdata_in;
      n_writes <= n_writes + 1;
    end
  end
  // Data only valid in the cycle after the strobe; it toggles otherwise so stale
  // values are never mistaken for an answer
  always @(negedge clock_in) begin
    rdata_out <= pend_q ? mem[pend_addr_q] : ~rdata_out;
  end
endmodule : cita_mem_model

// ==== tb/cita_core_tb.sv ====
`timescale 1ns/1ps
module cita_core_tb;
  logic clock_in;
  logic rstn_in;
  logic [7:0] rdata;
  logic [15:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [15:0] pc;
  logic [7:0] acc;
  logic [15:0] index;
  logic [15:0] stack;
  logic [7:0] flags;
  int n_errors;
  int comparisons;
  logic [7:0] prog [$];

  cita_core u_cita_core (.clock_in(clock_in), .rstn_in(rstn_in), .mem_rdata_in(rdata),
    .mem_addr_out(addr), .mem_rd_out(rd), .mem_wr_out(wr), .mem_wdata_out(wdata),
    .pc_out(pc), .acc_out(acc), .index_out(index), .stack_out(stack), .flags_out(flags));
  cita_mem_model u_cita_mem_model (.clock_in(clock_in), .addr_in(addr), .rd_in(rd),
    .wr_in(wr), .wdata_in(wdata), .rdata_out(rdata));

  initial clock_in = 1'b0;
  always #2 clock_in = ~clock_in;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  function automatic logic [7:0] ftest_ccr(input logic [7:0] c, input logic [7:0] m);
    ftest_ccr = {1'b0, c[6:3], m[7], m == 8'h00, c[0]};
  endfunction : ftest_ccr

  task automatic poke(input logic [15:0] a, input logic [7:0] d);
    u_cita_mem_model.mem[a] = d;
  endtask : poke

  // Holds reset, blanks memory with a no-operation opcode and loads the program
  task automatic restart();
    @(negedge clock_in);
    rstn_in = 1'b0;
    for (int i = 0; i < 65536; i++) u_cita_mem_model.mem[i] = 8'h9d;
    foreach (prog[i]) u_cita_mem_model.mem[i] = prog[i];
    u_cita_mem_model.n_writes = 0;
    repeat (10) @(negedge clock_in);
  endtask : restart

  // Releases reset and waits for the opcode fetch at the given address
  task automatic run(input logic [15:0] last);
    logic found;
    found = 1'b0;
    check(pc, 16'h0000);
    check(stack, 16'h00ff);
    check(16'(flags), 16'h0068);
    check({index[7:0], acc}, 16'h0000);
    check({14'h0, rd, wr}, 16'h0000);
    rstn_in = 1'b1;
    for (int k = 0; k < 400 && !found; k++) begin
      @(negedge clock_in);
      found = (rd === 1'b1) && (addr === last);
    end
    check(16'(found), 16'h0001);
    // Let the last instruction's register updates land
    repeat (4) @(negedge clock_in);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock_in);
    n_errors++;
    stop_test();
  end

  initial begin
    logic [7:0] c, m, e, a, b, ii, r;
    logic [15:0] h1, ee, vec;
    rstn_in = 1'b0;
    n_errors = 0;
    comparisons = 0;
    void'($urandom(32'hd7ceeeef));
    // Extended load, flags from acc, flag test of memory, flags back to acc and index
    for (int t = 0; t < 8; t++) begin
      c = 8'($urandom);
      m = (t == 0) ? 8'h00 : (t == 1) ? 8'h80 : 8'($urandom);
      h1 = 16'h1000 + 16'($urandom % 32'h3000);
      prog = {8'hc6, h1[15:8], h1[7:0], 8'h84, 8'h3d, 8'h50, 8'h85, 8'h97, 8'h5d};
      restart();
      poke(h1, c);
      poke(16'h0050, m);
      run(16'h0009);
      e = ftest_ccr(c | 8'h60, m);
      check(16'(flags), 16'(ftest_ccr(e, e))); // Flags
      check(16'(acc), 16'(e)); // Acc
      check(index, {8'h00, e}); // Index
    end
    // Stack transfers, wide-offset load, stack-offset flag test
    ee = 16'h1000 + 16'($urandom % 32'h3000);
    b = 8'($urandom) | 8'h80;
    m = 8'($urandom);
    prog = {8'h95, 8'hd6, ee[15:8], ee[7:0], 8'h94, 8'h9e, 8'h6d, 8'hff};
    restart();
    poke(16'h0100 + ee, b);
    poke(16'h01fe, m);
    run(16'h0008);
    check(index, 16'h0100); // Stack plus one
    check(stack, 16'h00ff); // Index minus one
    check(16'(acc), 16'(b)); // Wide offset
    check(16'(flags), 16'(ftest_ccr(8'h68, m))); // Stack offset
    // Software trap after loading index, flags and acc
    a = 8'($urandom) & 8'hf7;
    b = 8'($urandom);
    // Even address so the second operand byte never wraps its low byte
    h1 = (16'h1000 + 16'($urandom % 32'h3000)) & 16'hfffe;
    vec = {8'h40, 8'($urandom)};
    prog = {8'hc6, h1[15:8], h1[7:0], 8'h97, 8'h84};
    prog = {prog, 8'hc6, h1[15:8], h1[7:0] + 8'h01, 8'h83};
    restart();
    poke(h1, a);
    poke(h1 + 16'h0001, b);
    poke(16'hfff0, vec[15:8]);
    poke(16'hfff1, vec[7:0]);
    run(vec);
    e = ftest_ccr(a | 8'h60, b);
    check(16'(u_cita_mem_model.mem[16'h00ff]), 16'h0009); // Return low
    check(16'(u_cita_mem_model.mem[16'h00fe]), 16'h0000); // Return high
    check(16'(u_cita_mem_model.mem[16'h00fd]), 16'(a)); // Index low
    check(16'(u_cita_mem_model.mem[16'h00fc]), 16'(b)); // Acc
    check(16'(u_cita_mem_model.mem[16'h00fb]), 16'(e)); // Flags
    check(16'(u_cita_mem_model.n_writes), 16'h0005); // Five pushes
    check(stack, 16'h00fa); // Stack moved
    check(16'(flags), 16'(e | 8'h08)); // Mask set
    // Moves, then taken branches that skip a flags-to-acc opcode
    ii = 8'($urandom);
    r = 8'($urandom);
    prog = {8'h95, 8'h6e, ii, 8'h40, 8'h5e, 8'h40, 8'h7e, 8'h41, 8'h71, 8'h01, 8'h85};
    prog = {prog, 8'h61, 8'hff, 8'h01, 8'h85, 8'h31, 8'h42, 8'h01, 8'h85};
    prog = {prog, 8'h01, 8'h43, 8'h01, 8'h85};
    restart();
    poke(16'h0101, r);
    poke(16'h0102, 8'h00);
    poke(16'h0202, 8'h00);
    poke(16'h0042, 8'h00);
    poke(16'h0043, 8'hfe);
    run(16'h0017);
    check(16'(u_cita_mem_model.mem[16'h0040]), 16'(ii)); // Immediate move
    check(16'(u_cita_mem_model.mem[16'h0100]), 16'(ii)); // Direct to indexed
    check(16'(u_cita_mem_model.mem[16'h0041]), 16'(r)); // Indexed to direct
    check(index, 16'h0104); // Four increments
    check(16'(acc), 16'h0000); // All branches taken
    check(16'(flags[0]), 16'h0000); // Tested bit to carry
    stop_test();
  end
endmodule : cita_core_tb
